// file: include/port_link_pkg.sv
package port_link_pkg;

  localparam int ADDR_W = 8;

  // Register byte addresses
  localparam logic [7:0] DEV_CTL2_OFFSET = 8'h00;
  localparam logic [7:0] LINK_CAP_OFFSET = 8'h04;
  localparam logic [7:0] LINK_CTL_OFFSET = 8'h08;
  localparam logic [7:0] TARGET_SPEED_OFFSET = 8'h0c;
  localparam logic [7:0] EVENT_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] LTR_VALUE_OFFSET = 8'h14;
  localparam logic [7:0] EP_DEV_CTL2_OFFSET = 8'h18;

  // Device control 2 field positions
  localparam int CTO_DISABLE_BIT = 4;
  localparam int ATOMIC_REQ_EN_BIT = 6;
  localparam int ATOMIC_BLOCK_BIT = 7;
  localparam int IDO_REQ_EN_BIT = 8;
  localparam int IDO_CPL_EN_BIT = 9;
  localparam int LTR_EN_BIT = 10;
  localparam int POWER_REDUCE_BIT = 11;
  localparam int TAG10_EN_BIT = 12;
  localparam int OBFF_EN_LSB = 13;
  localparam int PREFIX_BLOCK_BIT = 15;

  // Link control and status field positions
  localparam int LINK_DISABLE_BIT = 4;
  localparam int RETRAIN_BIT = 5;
  localparam int BW_STATUS_WORD_BIT = 30;

  // Event status bits
  localparam int EV_ATOMIC_DISCARD = 0;
  localparam int EV_PREFIX_BLOCKED = 1;
  localparam int EV_LTR_PENDING = 2;

  // Reset values
  localparam logic [15:0] DEV_CTL2_RESET = 16'h0000;
  localparam logic [15:0] LINK_CTL_RESET = 16'h0000;
  localparam logic [15:0] EP_DEV_CTL2_RESET = 16'h0000;
  localparam logic [3:0] DEFAULT_SPEED = 4'h1;
  localparam logic [5:0] DEFAULT_WIDTH = 6'h01;
  localparam logic [7:0] DEFAULT_PORT_NUMBER = 8'h00;
  localparam logic [2:0] L1_EXIT_LATENCY = 3'h0;

  // Link training time
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TRAIN_TIME_NS = 1000;
  localparam int TRAIN_CYCLES =
    (TRAIN_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    LINK_DOWN = 3'b001,
    LINK_TRAIN = 3'b010,
    LINK_UP = 3'b100
  } link_state_type;

endpackage

// file: rtl/integrated_port_link_device_ctrl.sv
`timescale 1ns/1ps
module integrated_port_link_device_ctrl
#(
  parameter bit ATOMIC_COMPLETER = 1'b1,
  parameter bit FORWARDS = 1'b0,
  parameter bit IDO_CAPABLE = 1'b1,
  parameter bit LTR_SUPPORTED = 1'b1,
  parameter bit OBFF_SUPPORTED = 1'b1,
  parameter logic [7:0] PORT_NUMBER = port_link_pkg::DEFAULT_PORT_NUMBER,
  parameter logic [3:0] MAX_SPEED = port_link_pkg::DEFAULT_SPEED,
  parameter logic [5:0] MAX_WIDTH = port_link_pkg::DEFAULT_WIDTH,
  parameter int TRAIN_COUNT = port_link_pkg::TRAIN_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [port_link_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [port_link_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [3:0] ep_target_speed,
  input wire logic atomic_req_valid,
  output logic atomic_accept,
  output logic atomic_error_resp,
  output logic atomic_discard,
  input wire logic tlp_valid,
  input wire logic tlp_has_prefix,
  output logic tlp_forward,
  output logic tlp_prefix_blocked,
  input wire logic ltr_msg_valid,
  input wire logic [31:0] ltr_msg_value,
  input wire logic [1:0] obff_system_state,
  output logic [1:0] obff_to_ep,
  output logic ido_req_attr,
  output logic ido_cpl_attr,
  output logic ep_hot_reset
);
  import port_link_pkg::*;

  typedef struct packed {
    logic awready, wready, arready, bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, wdata, ltr_value;
    logic aw_held, w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [3:0] wstrb, rp_target, cur_speed;
    logic [15:0] dev_ctl2, ep_ctl2, link_ctl, train_count;
    link_state_type link_state;
    logic retrain_pend, training, dll_active, bw_status;
    logic [2:0] events;
    logic atomic_accept, atomic_error_resp, atomic_discard;
    logic tlp_forward, tlp_prefix_blocked;
    logic [1:0] obff_to_ep;
    logic ido_req_attr, ido_cpl_attr, ep_hot_reset;
  } state_type;

  // Writable bits; everything else is hardwired
  localparam logic [15:0] DEV_CTL2_MASK = {
    1'b1, 2'b11, 1'b1, 1'b0, 4'hf, ATOMIC_COMPLETER, 1'b1,
    FORWARDS, {4{FORWARDS}}};
  localparam logic [15:0] EP_CTL2_MASK = {
    3'b000, 1'b1, 2'b00, IDO_CAPABLE, IDO_CAPABLE, 8'h00};
  localparam logic [15:0] LINK_CTL_MASK = 16'hcfdb;
  localparam logic [15:0] TRAIN_LOAD = 16'(TRAIN_COUNT - 1);

  // Capability word is constant; zeros are hardwired fields
  localparam logic [31:0] LINK_CAP_VALUE = {
    PORT_NUMBER, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0,
    L1_EXIT_LATENCY, 3'h0, 2'b00, MAX_WIDTH, MAX_SPEED};

  state_type s;
  state_type next_s;
  logic [31:0] wr;
  logic [2:0] ev_set;
  logic [2:0] ev_clear;
  logic bw_set;
  logic bw_clear;
  logic retrain_req;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    for (int i = 0; i < 4; i++)
    begin
      res[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic [15:0] upd(input logic [15:0] old,
                                      input logic [31:0] data,
                                      input logic [3:0] strb,
                                      input logic [15:0] mask);
    logic [31:0] m;
    m = merge({16'h0, old}, data, strb);
    return (old & ~mask) | (m[15:0] & mask);
  endfunction

  always_comb
  begin
    next_s = s;
    wr = '0;
    ev_set = '0;
    ev_clear = '0;
    bw_set = 1'b0;
    bw_clear = 1'b0;
    retrain_req = 1'b0;
    next_s.atomic_accept = 1'b0;
    next_s.atomic_error_resp = 1'b0;
    next_s.atomic_discard = 1'b0;
    next_s.tlp_forward = 1'b0;
    next_s.tlp_prefix_blocked = 1'b0;

    // Address and data are taken in either order
    if (awvalid && s.awready)
    begin
      next_s.aw_held = 1'b1;
      next_s.awready = 1'b0;
      next_s.awaddr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.w_held = 1'b1;
      next_s.wready = 1'b0;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end

    if (s.aw_held && s.w_held && !s.bvalid)
    begin
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      wr = merge(32'h0, s.wdata, s.wstrb);
      case (s.awaddr)
        DEV_CTL2_OFFSET:
        begin
          next_s.dev_ctl2 = upd(s.dev_ctl2, s.wdata, s.wstrb, DEV_CTL2_MASK);
        end
        LINK_CTL_OFFSET:
        begin
          // Stored; only the link disable bit is read, by link training and ep_hot_reset
          next_s.link_ctl = upd(s.link_ctl, s.wdata, s.wstrb, LINK_CTL_MASK);
          retrain_req = wr[RETRAIN_BIT];
          bw_clear = wr[BW_STATUS_WORD_BIT];
        end
        TARGET_SPEED_OFFSET:
        begin
          next_s.rp_target = s.wstrb[0] ? s.wdata[3:0] : s.rp_target;
        end
        EVENT_STATUS_OFFSET:
        begin
          ev_clear = wr[2:0];
        end
        EP_DEV_CTL2_OFFSET:
        begin
          next_s.ep_ctl2 = upd(s.ep_ctl2, s.wdata, s.wstrb, EP_CTL2_MASK);
        end
        LINK_CAP_OFFSET, LTR_VALUE_OFFSET:
        begin
          next_s.bresp = RESP_OKAY;
        end
        default:
        begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.bvalid && bready)
    begin
      next_s.bvalid = 1'b0;
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    if (arvalid && s.arready)
    begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      case (araddr)
        DEV_CTL2_OFFSET: next_s.rdata = {16'h0, s.dev_ctl2};
        LINK_CAP_OFFSET: next_s.rdata = LINK_CAP_VALUE;
        LINK_CTL_OFFSET:
        begin
          // Retrain is never stored, so it reads zero
          next_s.rdata = {1'b0, s.bw_status, s.dll_active, 1'b0,
                          s.training, 1'b0, MAX_WIDTH, s.cur_speed,
                          s.link_ctl};
        end
        TARGET_SPEED_OFFSET:
        begin
          next_s.rdata = {20'h0, ep_target_speed, 4'h0, s.rp_target};
        end
        EVENT_STATUS_OFFSET: next_s.rdata = {29'h0, s.events};
        LTR_VALUE_OFFSET: next_s.rdata = s.ltr_value;
        EP_DEV_CTL2_OFFSET: next_s.rdata = {16'h0, s.ep_ctl2};
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end
    if (s.rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // Atomic requests from the host side
    if (atomic_req_valid)
    begin
      if (s.dev_ctl2[ATOMIC_BLOCK_BIT])
      begin
        next_s.atomic_discard = 1'b1;
        ev_set[EV_ATOMIC_DISCARD] = 1'b1;
      end
      else if (s.dev_ctl2[ATOMIC_REQ_EN_BIT])
      begin
        next_s.atomic_accept = 1'b1;
      end
      else
      begin
        next_s.atomic_error_resp = 1'b1;
      end
    end

    // Prefixed traffic is refused and logged while blocking is set
    if (tlp_valid)
    begin
      if (tlp_has_prefix && s.dev_ctl2[PREFIX_BLOCK_BIT])
      begin
        next_s.tlp_prefix_blocked = 1'b1;
        ev_set[EV_PREFIX_BLOCKED] = 1'b1;
      end
      else
      begin
        next_s.tlp_forward = 1'b1;
      end
    end

    // One-deep queue: a newer message overwrites an unread one
    if (ltr_msg_valid && LTR_SUPPORTED && s.dev_ctl2[LTR_EN_BIT])
    begin
      next_s.ltr_value = ltr_msg_value;
      ev_set[EV_LTR_PENDING] = 1'b1;
    end

    next_s.obff_to_ep = (OBFF_SUPPORTED &&
      s.dev_ctl2[OBFF_EN_LSB +: 2] != 2'b00) ?
      obff_system_state : 2'b00;
    next_s.ido_req_attr = s.ep_ctl2[IDO_REQ_EN_BIT];
    next_s.ido_cpl_attr = s.ep_ctl2[IDO_CPL_EN_BIT];
    next_s.ep_hot_reset = s.link_ctl[LINK_DISABLE_BIT];

    // Link training sequence
    unique case (s.link_state)
      LINK_DOWN:
      begin
        if (!s.link_ctl[LINK_DISABLE_BIT])
        begin
          next_s.link_state = LINK_TRAIN;
          next_s.train_count = TRAIN_LOAD;
          next_s.training = 1'b1;
        end
      end
      LINK_TRAIN:
      begin
        if (s.link_ctl[LINK_DISABLE_BIT])
        begin
          next_s.link_state = LINK_DOWN;
          next_s.training = 1'b0;
          next_s.retrain_pend = 1'b0;
        end
        else if (s.train_count == 16'h0)
        begin
          // Training drops one cycle ahead of link active
          next_s.link_state = LINK_UP;
          next_s.training = 1'b0;
          next_s.retrain_pend = 1'b0;
          bw_set = s.retrain_pend;
        end
        else
        begin
          next_s.train_count = s.train_count - 16'h1;
        end
      end
      LINK_UP:
      begin
        if (s.link_ctl[LINK_DISABLE_BIT])
        begin
          next_s.link_state = LINK_DOWN;
        end
      end
      default:
      begin
        next_s.link_state = LINK_TRAIN;
        next_s.train_count = TRAIN_LOAD;
      end
    endcase

    if (retrain_req && !s.link_ctl[LINK_DISABLE_BIT])
    begin
      next_s.link_state = LINK_TRAIN;
      next_s.train_count = TRAIN_LOAD;
      next_s.training = 1'b1;
      next_s.retrain_pend = 1'b1;
      if (s.rp_target != DEFAULT_SPEED || ep_target_speed != DEFAULT_SPEED)
      begin
        next_s.cur_speed = (s.rp_target < ep_target_speed) ?
          s.rp_target : ep_target_speed;
      end
    end

    next_s.dll_active = (s.link_state == LINK_UP);
    // A new event in the clearing cycle survives
    next_s.bw_status = (s.bw_status & ~bw_clear) | bw_set;
    next_s.events = (s.events & ~ev_clear) | ev_set;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.dev_ctl2 <= DEV_CTL2_RESET;
      s.ep_ctl2 <= EP_DEV_CTL2_RESET;
      s.link_ctl <= LINK_CTL_RESET;
      s.rp_target <= DEFAULT_SPEED;
      s.cur_speed <= DEFAULT_SPEED;
      s.link_state <= LINK_TRAIN;
      s.train_count <= TRAIN_LOAD;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign {awready, wready, bvalid, bresp} =
    {s.awready, s.wready, s.bvalid, s.bresp};
  assign {arready, rvalid, rdata, rresp} =
    {s.arready, s.rvalid, s.rdata, s.rresp};
  assign {atomic_accept, atomic_error_resp, atomic_discard} =
    {s.atomic_accept, s.atomic_error_resp, s.atomic_discard};
  assign {tlp_forward, tlp_prefix_blocked, obff_to_ep} =
    {s.tlp_forward, s.tlp_prefix_blocked, s.obff_to_ep};
  assign {ido_req_attr, ido_cpl_attr, ep_hot_reset} =
    {s.ido_req_attr, s.ido_cpl_attr, s.ep_hot_reset};

endmodule // integrated_port_link_device_ctrl

// file: tb/port_link_props.sv
`timescale 1ns/1ps
module port_link_props
  import port_link_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic atomic_req_valid,
  input wire logic atomic_accept,
  input wire logic atomic_error_resp,
  input wire logic atomic_discard,
  input wire logic tlp_valid,
  input wire logic tlp_has_prefix,
  input wire logic tlp_forward,
  input wire logic tlp_prefix_blocked,
  input wire logic [1:0] obff_system_state,
  input wire logic [1:0] obff_to_ep,
  input wire logic ido_req_attr,
  input wire logic ido_cpl_attr
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_atomic_one_answer:
    assert property (atomic_req_valid |=>
      $onehot({atomic_accept, atomic_error_resp, atomic_discard}))
    else $error("atomic answer count");
  a_atomic_quiet:
    assert property (!atomic_req_valid |=>
      !(atomic_accept || atomic_error_resp || atomic_discard))
    else $error("atomic answer unasked");
  a_tlp_plain_forward:
    assert property (tlp_valid && !tlp_has_prefix |=>
      tlp_forward && !tlp_prefix_blocked)
    else $error("plain tlp not forwarded");
  a_tlp_one_answer:
    assert property (tlp_valid |=> tlp_forward != tlp_prefix_blocked)
    else $error("tlp answer count");
  a_obff_follows:
    assert property (1'b1 |=> obff_to_ep == 2'b00 ||
      obff_to_ep == $past(obff_system_state))
    else $error("obff state not passed");
  a_ido_after_write:
    assert property ($changed({ido_req_attr, ido_cpl_attr}) |->
      $past(bvalid) || $past(bvalid, 2))
    else $error("ordering attribute moved alone");
  a_write_answer:
    assert property (awvalid && awready && wvalid && wready |->
      ##2 bvalid)
    else $error("write not answered");
  a_read_err_zero:
    assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read data not zero");

  c_discard: cover property (atomic_discard);
  c_error: cover property (atomic_error_resp);
  c_blocked: cover property (tlp_prefix_blocked);
endmodule // port_link_props

bind integrated_port_link_device_ctrl port_link_props props (.aclk,
  .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .rvalid,
  .rdata, .rresp, .atomic_req_valid, .atomic_accept, .atomic_error_resp,
  .atomic_discard, .tlp_valid, .tlp_has_prefix, .tlp_forward,
  .tlp_prefix_blocked, .obff_system_state, .obff_to_ep, .ido_req_attr,
  .ido_cpl_attr);

// file: tb/endpoint_model.sv
`timescale 1ns/1ps
module endpoint_model #(
  parameter int SEED = 32'h77ea
)
(
  input wire logic aclk,
  input wire logic en,
  input wire logic ep_hot_reset,
  output logic atomic_req_valid,
  output logic tlp_valid,
  output logic tlp_has_prefix,
  output logic ltr_msg_valid,
  output logic [31:0] ltr_msg_value,
  output logic [1:0] obff_system_state
);
  int seed = SEED;
  logic [31:0] r;
  logic go;

  // Held in hot reset it sends nothing; data lines churn regardless
  always @(posedge aclk)
  begin
    r = $random(seed);
    go = en && !ep_hot_reset;
    atomic_req_valid <= go && r[0];
    tlp_valid <= go && r[1];
    tlp_has_prefix <= r[2];
    ltr_msg_valid <= go && r[3] && r[4];
    ltr_msg_value <= $random(seed);
    obff_system_state <= r[6:5];
  end
endmodule // endpoint_model

// file: tb/integrated_port_link_device_ctrl_test.sv
`timescale 1ns/1ps
module integrated_port_link_device_ctrl_test;
  import port_link_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, en;
  logic awready, wready, bvalid, arready, rvalid, chk_on;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ltr_msg_value;
  logic [31:0] last_ltr = 32'h0;
  logic [3:0] wstrb, ep_target_speed;
  logic [1:0] bresp, rresp, obff_system_state, obff_to_ep, p_ob;
  logic atomic_req_valid, atomic_accept, atomic_error_resp, atomic_discard;
  logic tlp_valid, tlp_has_prefix, tlp_forward, tlp_prefix_blocked;
  logic ltr_msg_valid, ido_req_attr, ido_cpl_attr, ep_hot_reset;
  logic p_at, p_tv, p_pf;
  logic dis_any = 1'b0, blk_any = 1'b0, ltr_any = 1'b0;
  logic [15:0] ctl, ep_ctl;
  int mismatches, checked, seed;

  integrated_port_link_device_ctrl #(.PORT_NUMBER(8'h5a),
    .MAX_SPEED(4'h3), .MAX_WIDTH(6'h04), .TRAIN_COUNT(8)) dut (.aclk,
    .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .ep_target_speed, .atomic_req_valid,
    .atomic_accept, .atomic_error_resp, .atomic_discard, .tlp_valid,
    .tlp_has_prefix, .tlp_forward, .tlp_prefix_blocked, .ltr_msg_valid,
    .ltr_msg_value, .obff_system_state, .obff_to_ep, .ido_req_attr,
    .ido_cpl_attr, .ep_hot_reset);

  endpoint_model em (.aclk, .en, .ep_hot_reset, .atomic_req_valid,
    .tlp_valid, .tlp_has_prefix, .ltr_msg_valid, .ltr_msg_value,
    .obff_system_state);

  initial
  begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end

  // Answer {accept, error, discard}; blocking outranks the enable
  function automatic logic [2:0] f_at(input logic v, input logic [15:0] c);
    if (!v)
      return 3'b000;
    if (c[ATOMIC_BLOCK_BIT])
      return 3'b001;
    return c[ATOMIC_REQ_EN_BIT] ? 3'b100 : 3'b010;
  endfunction

  function automatic logic [1:0] f_tl(input logic v, p, input logic [15:0] c);
    if (!v)
      return 2'b00;
    return (p && c[PREFIX_BLOCK_BIT]) ? 2'b01 : 2'b10;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, s);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic lim(input int n);
    if (n >= 50)
    begin
      mismatches++;
      tally_and_finish;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 0;
      if (wready)
        wvalid <= 0;
      n++;
    end
    while (!bvalid && n < 50);
    lim(n);
    chk("bresp", {30'h0, r}, {30'h0, bresp});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, m,
                     input logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 0;
      n++;
    end
    while (!rvalid && n < 50);
    lim(n);
    chk("rdata", e, rdata & m);
    chk("rresp", {30'h0, r}, {30'h0, rresp});
  endtask

  always @(posedge aclk)
  begin
    p_at <= atomic_req_valid;
    p_tv <= tlp_valid;
    p_pf <= tlp_has_prefix;
    p_ob <= obff_system_state;
    if (ltr_msg_valid)
    begin
      last_ltr <= ltr_msg_value;
      ltr_any <= 1;
    end
  end

  always @(negedge aclk)
    if (chk_on === 1'b1)
    begin
      chk("atomic", {29'h0, f_at(p_at, ctl)}, {29'h0, atomic_accept,
        atomic_error_resp, atomic_discard});
      chk("tlp", {30'h0, f_tl(p_tv, p_pf, ctl)},
        {30'h0, tlp_forward, tlp_prefix_blocked});
      chk("obff", {30'h0, (ctl[14:13] != 2'b00) ? p_ob : 2'b00},
        {30'h0, obff_to_ep});
      chk("ido", {30'h0, ep_ctl[8], ep_ctl[9]},
        {30'h0, ido_req_attr, ido_cpl_attr});
      if (p_at && ctl[ATOMIC_BLOCK_BIT])
        dis_any = 1;
      if (p_tv && p_pf && ctl[PREFIX_BLOCK_BIT])
        blk_any = 1;
    end

  initial
  begin
    seed = 32'h77ea;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, en, chk_on} = 8'h0;
    {awaddr, araddr, wdata, wstrb, ep_target_speed} = 56'h0;
    {mismatches, checked} = 64'h0;
    {ctl, ep_ctl} = 32'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rdc(LINK_CAP_OFFSET, 32'h5a000043, 32'hff0c0fff, RESP_OKAY);
    wr(LINK_CAP_OFFSET, '1, RESP_OKAY);
    rdc(LINK_CAP_OFFSET, 32'h5a000043, 32'hff0c0fff, RESP_OKAY);
    rdc(DEV_CTL2_OFFSET, 32'h0, '1, RESP_OKAY);
    wr(DEV_CTL2_OFFSET, '1, RESP_OKAY);
    rdc(DEV_CTL2_OFFSET, 32'hf7e0, '1, RESP_OKAY);
    wr(8'h40, '1, RESP_SLVERR);
    rdc(8'h40, 32'h0, '1, RESP_SLVERR);
    // Every blocking and enable mix, latency reporting kept on
    for (int k = 0; k < 8; k++)
    begin
      ctl = 16'($random(seed));
      ctl[7:6] = k[1:0];
      ctl[15] = k[2];
      ctl[10] = 1;
      wr(DEV_CTL2_OFFSET, {16'h0, ctl}, RESP_OKAY);
      ctl = ctl & 16'hf7e0;
      ep_ctl = 16'($random(seed));
      wr(EP_DEV_CTL2_OFFSET, {16'h0, ep_ctl}, RESP_OKAY);
      @(posedge aclk);
      en <= 1;
      chk_on <= 1;
      repeat (40) @(posedge aclk);
      en <= 0;
      repeat (3) @(posedge aclk);
      chk_on <= 0;
    end
    rdc(EVENT_STATUS_OFFSET, {29'h0, ltr_any, blk_any, dis_any}, 32'h7,
      RESP_OKAY);
    rdc(LTR_VALUE_OFFSET, last_ltr, '1, RESP_OKAY);
    rdc(EP_DEV_CTL2_OFFSET, {16'h0, ep_ctl & 16'h1300}, '1, RESP_OKAY);
    wr(EVENT_STATUS_OFFSET, 32'h7, RESP_OKAY);
    rdc(EVENT_STATUS_OFFSET, 32'h0, 32'h7, RESP_OKAY);
    wr(LINK_CTL_OFFSET, 32'hffff, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("hot reset", 32'h1, {31'h0, ep_hot_reset});
    rdc(LINK_CTL_OFFSET, 32'hcfdb, 32'hffff, RESP_OKAY);
    wr(LINK_CTL_OFFSET, 32'h0, RESP_OKAY);
    repeat (30) @(posedge aclk);
    chk("hot reset", 32'h0, {31'h0, ep_hot_reset});
    ep_target_speed <= 4'h3;
    wr(TARGET_SPEED_OFFSET, 32'h2, RESP_OKAY);
    wr(LINK_CTL_OFFSET, 32'h20, RESP_OKAY);
    rdc(LINK_CTL_OFFSET, 32'h08020000, 32'h080f0020, RESP_OKAY);
    repeat (30) @(posedge aclk);
    rdc(LINK_CTL_OFFSET, 32'h60020000, 32'h680f0000, RESP_OKAY);
    tally_and_finish;
  end
endmodule // integrated_port_link_device_ctrl_test
